// ### rtl/brv_pkg.sv
`default_nettype none

package brv_pkg;

  // ==========================================================
  // register numbers
  localparam logic [15:0] ADDR_RATE_P1_Q01 = 16'h1C0F;
  localparam logic [15:0] ADDR_RATE_P1_Q23 = 16'h1C10;
  localparam logic [15:0] ADDR_RATE_P2_Q01 = 16'h1C11;
  localparam logic [15:0] ADDR_RATE_P2_Q23 = 16'h1C12;
  localparam logic [15:0] ADDR_TAG_P0 = 16'h1C13;
  localparam logic [15:0] ADDR_TAG_P1 = 16'h1C14;
  localparam logic [15:0] ADDR_TAG_P2 = 16'h1C15;
  localparam logic [15:0] ADDR_DROP_P0 = 16'h1C16;
  localparam logic [15:0] ADDR_DROP_P1 = 16'h1C17;
  localparam logic [15:0] ADDR_DROP_P2 = 16'h1C18;

  // ==========================================================
  // field layout
  localparam int RATE_W = 13;
  localparam int RATE_LO_LSB = 0;
  localparam int RATE_HI_LSB = 13;
  localparam int PRIO_W = 3;
  localparam int PRIO_LSB = 12;
  localparam int VID_W = 12;
  localparam int VID_LSB = 0;
  localparam int CNT_W = 32;

  // ==========================================================
  // reset values
  localparam logic [12:0] RATE_RST = 13'h0000;
  localparam logic [2:0] PRIO_RST = 3'h0;
  localparam logic [11:0] VID_RST = 12'h000;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================
  // timing: pacing unit per byte and the clock period
  localparam int RATE_UNIT_NS = 20;
  localparam int CLK_PERIOD_NS = 4;
  localparam int UNIT_CYCLES = (RATE_UNIT_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int NUM_QUEUES = 8;
  localparam int NUM_PORTS = 3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } brv_req_t;

  typedef struct packed {
    logic [2:0] prio;
    logic [11:0] vid;
  } brv_tag_t;

endpackage

`default_nettype wire

// ### rtl/brv_pacer.sv
`default_nettype none

module brv_pacer #(
  parameter int NQ = 8,
  parameter int UNIT = 5,
  parameter int CW = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // per-queue rate and byte events
  input wire logic [NQ-1:0][12:0] rate_i,
  input wire logic [NQ-1:0] byte_sent_i,
  // per-queue permission to send the next byte
  output logic [NQ-1:0] allow_o
);

  logic [NQ-1:0][CW-1:0] cnt;
  logic [NQ-1:0][CW-1:0] next_cnt;
  logic [NQ-1:0] next_allow;

  // ==========================================================
  // one interval timer per queue
  for (genvar q = 0; q < NQ; q++) begin : g_q
    logic [CW-1:0] span;
    // (rate + 1) units per byte
    assign span = CW'((32'(rate_i[q]) + 32'd1) * 32'(UNIT));

    always_comb begin
      next_cnt[q] = cnt[q];
      next_allow[q] = allow_o[q];
      // a byte sent while blocked is ignored and does not restart the timer
      if (byte_sent_i[q] && allow_o[q]) begin
        next_cnt[q] = span - CW'(1);
        next_allow[q] = (span == CW'(1));
      end else if (cnt[q] != '0) begin
        next_cnt[q] = cnt[q] - CW'(1);
        next_allow[q] = (cnt[q] == CW'(1));
      end else begin
        next_allow[q] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= '0;
      allow_o <= '1;
    end else begin
      cnt <= next_cnt;
      allow_o <= next_allow;
    end
  end

endmodule

`default_nettype wire

// ### rtl/brv_regs.sv
`default_nettype none

module brv_regs #(
  parameter int UNIT_CYCLES = brv_pkg::UNIT_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // register access from the management path
  input wire brv_pkg::brv_req_t req_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  // egress pacing, ports 1 and 2, queue index = (port-1)*4 + queue
  input wire logic [7:0] egress_byte_i,
  output logic [7:0] egress_allow_o,
  // default tag per port, used on tag insert or change
  output brv_pkg::brv_tag_t [2:0] default_tag_o,
  // ingress drop pulses per port (red, or yellow selected for drop)
  input wire logic [2:0] drop_i
);

  localparam int NQ = brv_pkg::NUM_QUEUES;
  localparam int NP = brv_pkg::NUM_PORTS;
  localparam int RW = brv_pkg::RATE_W;
  localparam int CW = brv_pkg::CNT_W;

  logic [NQ-1:0][RW-1:0] rate;
  logic [NQ-1:0][RW-1:0] next_rate;
  brv_pkg::brv_tag_t [NP-1:0] next_tag;
  logic [NP-1:0][CW-1:0] cnt;
  logic [NP-1:0][CW-1:0] next_cnt;
  logic [NP-1:0] rd_clr;
  logic [31:0] next_rdata;
  logic next_rvalid;

  // ==========================================================
  // write decode
  always_comb begin
    next_rate = rate;
    next_tag = default_tag_o;
    if (req_i.wr) begin
      if (req_i.addr == brv_pkg::ADDR_RATE_P1_Q01) begin
        next_rate[0] = req_i.wdata[brv_pkg::RATE_LO_LSB +: RW];
        next_rate[1] = req_i.wdata[brv_pkg::RATE_HI_LSB +: RW];
      end else if (req_i.addr == brv_pkg::ADDR_RATE_P1_Q23) begin
        next_rate[2] = req_i.wdata[brv_pkg::RATE_LO_LSB +: RW];
        next_rate[3] = req_i.wdata[brv_pkg::RATE_HI_LSB +: RW];
      end else if (req_i.addr == brv_pkg::ADDR_RATE_P2_Q01) begin
        next_rate[4] = req_i.wdata[brv_pkg::RATE_LO_LSB +: RW];
        next_rate[5] = req_i.wdata[brv_pkg::RATE_HI_LSB +: RW];
      end else if (req_i.addr == brv_pkg::ADDR_RATE_P2_Q23) begin
        next_rate[6] = req_i.wdata[brv_pkg::RATE_LO_LSB +: RW];
        next_rate[7] = req_i.wdata[brv_pkg::RATE_HI_LSB +: RW];
      end else if (req_i.addr == brv_pkg::ADDR_TAG_P0) begin
        next_tag[0].prio = req_i.wdata[brv_pkg::PRIO_LSB +:
                                       brv_pkg::PRIO_W];
        next_tag[0].vid = req_i.wdata[brv_pkg::VID_LSB +:
                                      brv_pkg::VID_W];
      end else if (req_i.addr == brv_pkg::ADDR_TAG_P1) begin
        next_tag[1].prio = req_i.wdata[brv_pkg::PRIO_LSB +:
                                       brv_pkg::PRIO_W];
        next_tag[1].vid = req_i.wdata[brv_pkg::VID_LSB +:
                                      brv_pkg::VID_W];
      end else if (req_i.addr == brv_pkg::ADDR_TAG_P2) begin
        next_tag[2].prio = req_i.wdata[brv_pkg::PRIO_LSB +:
                                       brv_pkg::PRIO_W];
        next_tag[2].vid = req_i.wdata[brv_pkg::VID_LSB +:
                                      brv_pkg::VID_W];
      end
      // counters and unmapped numbers ignore writes
    end
  end

  // ==========================================================
  // read decode; unused bits stay zero
  always_comb begin
    next_rdata = brv_pkg::RDATA_RST;
    next_rvalid = req_i.rd;
    rd_clr = '0;
    if (req_i.rd) begin
      if (req_i.addr == brv_pkg::ADDR_RATE_P1_Q01) begin
        next_rdata[brv_pkg::RATE_LO_LSB +: RW] = rate[0];
        next_rdata[brv_pkg::RATE_HI_LSB +: RW] = rate[1];
      end else if (req_i.addr == brv_pkg::ADDR_RATE_P1_Q23) begin
        next_rdata[brv_pkg::RATE_LO_LSB +: RW] = rate[2];
        next_rdata[brv_pkg::RATE_HI_LSB +: RW] = rate[3];
      end else if (req_i.addr == brv_pkg::ADDR_RATE_P2_Q01) begin
        next_rdata[brv_pkg::RATE_LO_LSB +: RW] = rate[4];
        next_rdata[brv_pkg::RATE_HI_LSB +: RW] = rate[5];
      end else if (req_i.addr == brv_pkg::ADDR_RATE_P2_Q23) begin
        next_rdata[brv_pkg::RATE_LO_LSB +: RW] = rate[6];
        next_rdata[brv_pkg::RATE_HI_LSB +: RW] = rate[7];
      end else if (req_i.addr == brv_pkg::ADDR_TAG_P0) begin
        next_rdata[brv_pkg::PRIO_LSB +: brv_pkg::PRIO_W] =
          default_tag_o[0].prio;
        next_rdata[brv_pkg::VID_LSB +: brv_pkg::VID_W] =
          default_tag_o[0].vid;
      end else if (req_i.addr == brv_pkg::ADDR_TAG_P1) begin
        next_rdata[brv_pkg::PRIO_LSB +: brv_pkg::PRIO_W] =
          default_tag_o[1].prio;
        next_rdata[brv_pkg::VID_LSB +: brv_pkg::VID_W] =
          default_tag_o[1].vid;
      end else if (req_i.addr == brv_pkg::ADDR_TAG_P2) begin
        next_rdata[brv_pkg::PRIO_LSB +: brv_pkg::PRIO_W] =
          default_tag_o[2].prio;
        next_rdata[brv_pkg::VID_LSB +: brv_pkg::VID_W] =
          default_tag_o[2].vid;
      end else if (req_i.addr == brv_pkg::ADDR_DROP_P0) begin
        next_rdata = cnt[0];
        rd_clr[0] = 1'b1;
      end else if (req_i.addr == brv_pkg::ADDR_DROP_P1) begin
        next_rdata = cnt[1];
        rd_clr[1] = 1'b1;
      end else if (req_i.addr == brv_pkg::ADDR_DROP_P2) begin
        next_rdata = cnt[2];
        rd_clr[2] = 1'b1;
      end
    end
  end

  // ==========================================================
  // drop counters
  for (genvar p = 0; p < NP; p++) begin : g_cnt
    logic [CW-1:0] base;
    always_comb begin
      // clear first, then add, so a coincident drop survives
      base = rd_clr[p] ? brv_pkg::CNT_RST : cnt[p];
      next_cnt[p] = base;
      if (drop_i[p] && (base != '1)) begin
        next_cnt[p] = base + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rate <= {NQ{brv_pkg::RATE_RST}};
      for (int i = 0; i < NP; i++) begin
        default_tag_o[i].prio <= brv_pkg::PRIO_RST;
        default_tag_o[i].vid <= brv_pkg::VID_RST;
        cnt[i] <= brv_pkg::CNT_RST;
      end
      rdata_o <= brv_pkg::RDATA_RST;
      rvalid_o <= 1'b0;
    end else begin
      rate <= next_rate;
      default_tag_o <= next_tag;
      cnt <= next_cnt;
      rdata_o <= next_rdata;
      rvalid_o <= next_rvalid;
    end
  end

  // ==========================================================
  // egress byte pacing
  brv_pacer #(
    .NQ(NQ),
    .UNIT(UNIT_CYCLES),
    .CW(16)
  ) u_pacer (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .rate_i(rate),
    .byte_sent_i(egress_byte_i),
    .allow_o(egress_allow_o)
  );

endmodule

`default_nettype wire

// ### verification/brv_regs_props.sv
`default_nettype none

// ==========================================
// register bank checker
module brv_regs_props #(
  parameter int UNIT_CYCLES = 5
) (
  // clock, reset and requests
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire brv_pkg::brv_req_t req_i,
  input wire logic [7:0] egress_byte_i,
  input wire logic [2:0] drop_i,
  // answers
  input wire logic [31:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [7:0] egress_allow_o,
  input wire brv_pkg::brv_tag_t [2:0] default_tag_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  rd_answer_a: assert property (req_i.rd |=> rvalid_o)
    else $error("read without answer");
  no_read_a: assert property (!req_i.rd |=> !rvalid_o)
    else $error("answer without read");
  rate_rsvd_a: assert property (rvalid_o && $past(req_i.addr) inside
    {[brv_pkg::ADDR_RATE_P1_Q01:brv_pkg::ADDR_RATE_P2_Q23]}
    |-> rdata_o[31:26] == 6'h00) else $error("rate reserved bits set");
  tag_rsvd_a: assert property (rvalid_o && $past(req_i.addr) inside
    {[brv_pkg::ADDR_TAG_P0:brv_pkg::ADDR_TAG_P2]}
    |-> rdata_o[31:15] == 17'h0) else $error("tag reserved bits set");
  unmapped_zero_a: assert property (rvalid_o &&
    !($past(req_i.addr) inside
    {[brv_pkg::ADDR_RATE_P1_Q01:brv_pkg::ADDR_DROP_P2]})
    |-> rdata_o == 32'h0) else $error("unmapped read not zero");
  tag_write_a: assert property (req_i.wr &&
    req_i.addr == brv_pkg::ADDR_TAG_P1
    |=> default_tag_o[1] == $past(req_i.wdata[14:0]))
    else $error("tag output not updated");
  tag_hold_a: assert property (!(req_i.wr && req_i.addr inside
    {[brv_pkg::ADDR_TAG_P0:brv_pkg::ADDR_TAG_P2]})
    |=> $stable(default_tag_o)) else $error("tag output moved");
  pace_gap_a: assert property (egress_byte_i[0] && egress_allow_o[0]
    |=> !egress_allow_o[0] [*4]) else $error("byte interval too short");
  allow_hold_a: assert property (egress_allow_o[7] && !egress_byte_i[7]
    |=> egress_allow_o[7]) else $error("allow dropped while idle");

  // cycles since queue 7 last had a byte taken, stuck at all ones
  logic [15:0] since_byte;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      since_byte <= 16'h0000;
    end else if (egress_byte_i[7] && egress_allow_o[7]) begin
      since_byte <= 16'h0001;
    end else if (since_byte != 16'h0000 && since_byte != 16'hFFFF) begin
      since_byte <= since_byte + 16'h0001;
    end
  end
  // even a zero rate spaces bytes by one full unit
  pace_min_a: assert property ($rose(egress_allow_o[7])
    |-> since_byte >= 16'(UNIT_CYCLES)) else $error("allow back too early");
endmodule

bind brv_regs brv_regs_props #(.UNIT_CYCLES(UNIT_CYCLES)) i_brv_regs_props (
  .mclk_i(mclk_i), .reset_i(reset_i), .req_i(req_i),
  .egress_byte_i(egress_byte_i), .drop_i(drop_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .egress_allow_o(egress_allow_o),
  .default_tag_o(default_tag_o));

`default_nettype wire

// ### verification/brv_regs_tb.sv
`default_nettype none

module brv_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int U = 5;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  brv_pkg::brv_req_t req_i = '0;
  logic [7:0] egress_byte_i = 8'h00;
  logic [2:0] drop_i = 3'h0;
  logic [31:0] rdata_o;
  logic rvalid_o;
  logic [7:0] egress_allow_o;
  brv_pkg::brv_tag_t [2:0] default_tag_o;
  int n_fail = 0;
  int cmp_count = 0;
  int n, k, q;
  logic [31:0] d, v;
  logic [15:0] a16;

  always #2 mclk_i = ~mclk_i;

  brv_regs #(.UNIT_CYCLES(U)) i_brv_regs (.mclk_i(mclk_i),
    .reset_i(reset_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .egress_byte_i(egress_byte_i),
    .egress_allow_o(egress_allow_o), .default_tag_o(default_tag_o),
    .drop_i(drop_i));

  // ==========================================
  // helpers
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // readable image: reserved bits and counters' writes vanish
  function automatic logic [31:0] img(input logic [15:0] a,
                                      input logic [31:0] w);
    if (a inside {[16'h1C0F:16'h1C12]}) return w & 32'h03FF_FFFF;
    if (a inside {[16'h1C13:16'h1C15]}) return w & 32'h0000_7FFF;
    return 32'h0000_0000;
  endfunction

  task automatic wr(input logic [15:0] a, input logic [31:0] w);
    @(posedge mclk_i) #1;
    req_i = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: w};
    @(posedge mclk_i) #1;
    req_i.wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [2:0] dm,
                    output logic [31:0] r);
    @(posedge mclk_i) #1;
    req_i = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    drop_i = dm;
    @(posedge mclk_i) #1;
    req_i.rd = 1'b0;
    drop_i = 3'h0;
    chk({31'h0, rvalid_o}, 32'h1);
    r = rdata_o;
  endtask

  task automatic drops(input logic [2:0] m, input int cnt);
    repeat (cnt) begin
      @(posedge mclk_i) #1;
      drop_i = m;
    end
    @(posedge mclk_i) #1;
    drop_i = 3'h0;
  endtask

  // ==========================================
  // main sequence
  initial begin
    n = $urandom(89445);
    repeat (12) @(posedge mclk_i);
    #1 reset_i = 1'b0;
    chk({24'h0, egress_allow_o}, 32'hFF);
    chk({17'h0, default_tag_o[2]}, 32'h0);
    for (int a = 16'h1C0F; a <= 16'h1C19; a++) begin
      rd(16'(a), 3'h0, v);
      chk(v, 32'h0);
    end
    for (int i = 0; i < 40; i++) begin
      a16 = 16'h1C0F + 16'($urandom_range(10));
      d = $urandom();
      if (i < 3) d = 32'hFFFF_FFFF;
      wr(a16, d);
      rd(a16, 3'h0, v);
      chk(v, img(a16, d));
      if (a16 inside {[16'h1C13:16'h1C15]}) begin
        v = {17'h0, default_tag_o[2'(a16 - 16'h1C13)]};
        chk(v, img(a16, d));
      end
    end
    for (int p = 0; p < 3; p++) begin
      n = $urandom_range(1, 20);
      drops(3'(1 << p), n);
      rd(16'h1C16 + 16'(p), 3'(1 << p), v);
      chk(v, 32'(n));
      rd(16'h1C16 + 16'(p), 3'h0, v);
      chk(v, 32'h1);
      rd(16'h1C16 + 16'(p), 3'h0, v);
      chk(v, 32'h0);
    end
    for (int c = 0; c < 2; c++) begin
      n = $urandom_range(0, 6);
      q = c ? 7 : 0;
      wr(c ? 16'h1C12 : 16'h1C0F, c ? 32'(n) << 13 : 32'(n));
      egress_byte_i = 8'(1 << q);
      chk({31'h0, egress_allow_o[q]}, 32'h1);
      k = 0;
      do begin
        @(posedge mclk_i) #1;
        k++;
      end while (egress_allow_o[q] !== 1'b1 && k < 100);
      if (k >= 100) begin
        n_fail++;
        stop_test();
      end
      chk(32'(k), 32'((n + 1) * U));
      egress_byte_i = 8'h00;
    end
    stop_test();
  end
endmodule

`default_nettype wire
